//--- charger_defs.svh
// Register offsets, field positions, reset values and timing counts of the charger control block
`ifndef CHARGER_DEFS_SVH
`define CHARGER_DEFS_SVH

// ==========================================================================
// Register offsets on the serial register port
`define OFS_CONTROL_FIRST   8'h01
`define OFS_INTERRUPT       8'h02
`define OFS_ENABLE_CONTROL  8'h03
`define OFS_OUTPUT_CONFIG   8'h04

// ==========================================================================
// First control register fields
`define BIT_INT_POLARITY    7
`define BIT_GLOBAL_INT_EN   6
`define BIT_USB_SWITCH      5
`define BIT_CHARGE_PUMP     4
`define BIT_LOW_POWER       3
`define BIT_SOURCE_TIME     2
`define BIT_MANUAL_DETECT   1
`define BIT_DETECT_ENABLE   0
`define RST_CONTROL_FIRST   8'h09

// ==========================================================================
// Interrupt register fields
`define POS_TYPE_HI         7
`define POS_TYPE_LO         5
`define BIT_BUS_COMPARATOR  4
`define BIT_CONTACT_TIMEOUT 2
`define BIT_DETECT_RUNNING  1

// ==========================================================================
// Enable-output control register fields
`define BIT_CONTACT_DET_EN  7
`define BIT_SUSPEND_SELECT  4
`define BIT_OUTPUT_FORCE    3
`define RST_ENABLE_CONTROL  8'h80

// ==========================================================================
// Output and regulator configuration register fields
`define BIT_PORT_METHOD     4
`define BIT_COMPLIANCE      3
`define BIT_REG_OUT_ENABLE  2
`define BIT_REG_OUT_TIMING  1
`define BIT_TIMEOUT_EXIT    0
`define RST_OUTPUT_CONFIG   8'h0B

// ==========================================================================
// Charger type codes
`define TYPE_NOTHING        3'h0
`define TYPE_USB_CABLE      3'h1
`define TYPE_CHARGING_PORT  3'h2
`define TYPE_DEDICATED      3'h3
`define TYPE_SPECIAL_SMALL  3'h4
`define TYPE_SPECIAL_LARGE  3'h5
`define TYPE_RESERVED       3'h6
`define TYPE_ALL_ON         3'h7

// ==========================================================================
// Timing
`define SYS_CLK_MHZ         20
`define DEBOUNCE_TIME_US    30000
`define DEBOUNCE_CYCLES     (`DEBOUNCE_TIME_US * `SYS_CLK_MHZ)

`endif

//--- charger_pkg.sv
// Types shared by the charger control block
package charger_pkg;

  // ==========================================================================
  // Detection sequencing states
  typedef enum logic [0:0] {
    DET_IDLE,
    DET_RUN
  } det_state_t;

endpackage : charger_pkg

//--- level_debounce.sv
// Per-bit stability filter: a level passes only after holding for CYCLES clocks
`timescale 1ns/10ps
module level_debounce #(
  parameter int WIDTH  = 1,
  parameter int CYCLES = 600000
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Levels
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] level_out
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  // ==========================================================================
  // One counter per bit; any return to agreement with the output restarts the hold interval
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic [CW-1:0] cnt_q;
      logic [CW-1:0] cnt_d;
      logic          out_q;
      wire           differs = level_in[i] != out_q;
      wire           expired = cnt_q == LAST;

      assign cnt_d = !differs ? '0 : (expired ? '0 : cnt_q + CW'(1));

      // Hold counter and filtered level
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_q <= '0;
          out_q <= 1'b0;
        end else begin
          cnt_q <= cnt_d;
          if (differs && expired) out_q <= level_in[i];
        end
      end

      assign level_out[i] = out_q;
    end
  endgenerate

endmodule : level_debounce

//--- charger_detect_enable_control.sv
// Charger-enable outputs, regulator timing, interrupts and detection start control
`timescale 1ns/10ps
`include "charger_defs.svh"

// Summary of operation
// - Suspend-select bit 4 picks disabled pattern: first high only, or all three high.
// - Force bit 3 makes enable outputs follow the host field, not detection.
// - Output field holds third, second, first; detection loads it unless forced.
// - Third control bit 4 selects normal or resistive downstream-port detection.
// - Compliance bit 3 changes the enable pattern for a plain USB cable.
// - Regulated-output enable bit 2 keeps the output off when clear.
// - Timing bit 1: output on at detection end, or at valid bus voltage.
// - Timeout-exit bit 0 ends detection once the contact timeout flag rises.
// - Interrupt on comparator change, dead-battery rise, or contact-timeout rise.
// - Global enable clear masks the interrupt pin but keeps pending events.
// - Only a read of the interrupt register clears pending events.
// - Bus insertion or removal must hold 30 ms before it interrupts.
// - Low-power mode stops oscillator only without bus, switch or pump.
// - Analog switches go high impedance only while low-power mode has the oscillator stopped.
// - Detection starts on valid bus voltage when detect enable bit 0 is set, or on manual request.
// - Data switches open during detection, then return to prior state.
// - External enable high, or type 000 or 110, gives disabled pattern.
// - Type 001 gives 100 when not compliant, else disabled pattern.
// - Enable low: types 010, 011, 101 give 010; 100 gives 100; 111 gives 000.
// - Interrupt register bits 7 to 5 report the detected cable type.
// - Manual request bit clears itself when the detection completes.
module charger_detect_enable_control
  import charger_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // Register port from the serial front end
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Pins from outside the clock domain
  input  wire logic       bus_voltage_comparator,
  input  wire logic       ext_enable,
  // Detection sequencer
  input  wire logic       det_done,
  input  wire logic [2:0] det_result,
  input  wire logic       dead_battery_charge_flag,
  input  wire logic       contact_detect_timeout_flag,
  output logic            det_start,
  output logic            det_abort,
  output logic            det_running,
  output logic            downstream_port_detect_method,
  output logic            source_time_long,
  output logic            contact_detect_enable,
  // Charger enable outputs
  output logic            enable_out_third,
  output logic            enable_out_second,
  output logic            enable_out_first,
  // Regulator, switches, power
  output logic            regulated_output,
  output logic            usb_switch_closed,
  output logic            analog_switch_hiz,
  output logic            charge_pump_enable,
  output logic            oscillator_stop,
  // Interrupt pin
  output logic            interrupt_out
);

  // ==========================================================================
  // Reset release through two flip-flops
  logic [1:0] rst_sync_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) rst_sync_q <= 2'b00;
    else       rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  wire rst_n = rst_sync_q[1];

  // ==========================================================================
  // Pin synchronisers: three stages, change accepted when stages two and three agree
  wire  [1:0] pin_raw = {ext_enable, bus_voltage_comparator};
  logic [1:0] pin_flt;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      logic [2:0] sync_q;
      logic       flt_q;
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync_q <= 3'b000;
          flt_q  <= 1'b0;
        end else begin
          sync_q <= {sync_q[1:0], pin_raw[g]};
          if (sync_q[1] == sync_q[2]) flt_q <= sync_q[2];
        end
      end
      assign pin_flt[g] = flt_q;
    end
  endgenerate
  wire ext_enable_s = pin_flt[1];

  // Bus presence must hold for the debounce interval before it counts
  logic bus_valid;
  level_debounce #(
    .WIDTH  (1),
    .CYCLES (DEBOUNCE_CYCLES)
  ) u_bus_debounce (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .level_in  (pin_flt[0]),
    .level_out (bus_valid)
  );

  // ==========================================================================
  // Register storage
  logic [7:0] ctrl1_q, ctrl2_q, ctrl3_q;
  logic [2:0] type_q;
  logic [2:0] pend_q, pend_d;
  logic       bus_prev_q, dead_prev_q, tmo_prev_q;
  logic       switch_save_q, complete_q;
  logic [7:0] rdata_q;
  det_state_t state_q;

  // Decoded accesses
  wire wr_ctrl1 = reg_wr && (reg_addr == `OFS_CONTROL_FIRST);
  wire wr_ctrl2 = reg_wr && (reg_addr == `OFS_ENABLE_CONTROL);
  wire wr_ctrl3 = reg_wr && (reg_addr == `OFS_OUTPUT_CONFIG);
  wire rd_int   = reg_rd && (reg_addr == `OFS_INTERRUPT);

  // Named control fields
  wire int_polarity  = ctrl1_q[`BIT_INT_POLARITY];
  wire global_int_en = ctrl1_q[`BIT_GLOBAL_INT_EN];
  wire usb_switch_control   = ctrl1_q[`BIT_USB_SWITCH];
  wire low_power_select     = ctrl1_q[`BIT_LOW_POWER];
  wire manual_detection_request = ctrl1_q[`BIT_MANUAL_DETECT];
  wire charger_detect_enable    = ctrl1_q[`BIT_DETECT_ENABLE];
  wire suspend_select       = ctrl2_q[`BIT_SUSPEND_SELECT];
  wire enable_output_force  = ctrl2_q[`BIT_OUTPUT_FORCE];
  wire compliance_select    = ctrl3_q[`BIT_COMPLIANCE];
  wire regulated_output_enable        = ctrl3_q[`BIT_REG_OUT_ENABLE];
  wire regulated_output_assert_timing = ctrl3_q[`BIT_REG_OUT_TIMING];
  wire contact_timeout_exit = ctrl3_q[`BIT_TIMEOUT_EXIT];

  // ==========================================================================
  // Charger-enable pattern from detection result
  wire [2:0] off_pattern = suspend_select ? 3'b001 : 3'b111;

  function automatic logic [2:0] map_type(input logic [2:0] t, input logic en,
                                          input logic cpl, input logic [2:0] off);
    logic [2:0] r;
    r = off;
    if (!en) begin
      unique case (t)
        `TYPE_NOTHING, `TYPE_RESERVED: r = off;
        `TYPE_USB_CABLE:     r = cpl ? off : 3'b100;
        `TYPE_CHARGING_PORT, `TYPE_DEDICATED,
        `TYPE_SPECIAL_LARGE: r = 3'b010;
        `TYPE_SPECIAL_SMALL: r = 3'b100;
        `TYPE_ALL_ON:        r = 3'b000;
      endcase
    end
    return r;
  endfunction

  wire [2:0] fsm_pattern = map_type(type_q, ext_enable_s, compliance_select,
                                    off_pattern);

  // ==========================================================================
  // Detection sequencing
  wire bus_rise   = bus_valid && !bus_prev_q;
  wire tmo_rise   = contact_detect_timeout_flag && !tmo_prev_q;
  wire want_start = (bus_rise && charger_detect_enable) || manual_detection_request;
  wire start_now  = (state_q == DET_IDLE) && want_start;
  wire exit_now   = (state_q == DET_RUN) && contact_timeout_exit && tmo_rise;
  wire done_now   = (state_q == DET_RUN) && det_done;
  wire finish     = exit_now || done_now;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= DET_IDLE;
      switch_save_q <= 1'b0;
    end else begin
      unique case (state_q)
        DET_IDLE: begin
          if (start_now) begin
            state_q       <= DET_RUN;
            switch_save_q <= usb_switch_control;
          end
        end
        DET_RUN: begin
          if (finish) state_q <= DET_IDLE;
        end
      endcase
    end
  end

  // Result capture and completion flag for the regulator timing
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      type_q     <= `TYPE_NOTHING;
      complete_q <= 1'b0;
    end else begin
      if (done_now) type_q <= det_result;
      else if (!bus_valid && !manual_detection_request && state_q == DET_IDLE)
        type_q <= `TYPE_NOTHING;
      if (finish) complete_q <= 1'b1;
      else if (start_now || !bus_valid) complete_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Control registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_q <= `RST_CONTROL_FIRST;
    end else if (wr_ctrl1) begin
      ctrl1_q <= reg_wdata;                                    // host set wins over self-clear
    end else begin
      if (finish) ctrl1_q[`BIT_MANUAL_DETECT] <= 1'b0;
      if (finish) ctrl1_q[`BIT_USB_SWITCH] <= switch_save_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl2_q <= `RST_ENABLE_CONTROL;
    end else begin
      if (wr_ctrl2) ctrl2_q[7:3] <= reg_wdata[7:3];
      if (wr_ctrl2 && reg_wdata[`BIT_OUTPUT_FORCE])
        ctrl2_q[2:0] <= reg_wdata[2:0];
      else if (!enable_output_force && !(wr_ctrl2 && reg_wdata[`BIT_OUTPUT_FORCE]))
        ctrl2_q[2:0] <= fsm_pattern;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) ctrl3_q <= `RST_OUTPUT_CONFIG;
    else if (wr_ctrl3) ctrl3_q <= reg_wdata;
  end

  // ==========================================================================
  // Pending interrupt events; a new event wins over a clearing read
  wire [2:0] events = {tmo_rise,
                       dead_battery_charge_flag && !dead_prev_q,
                       bus_valid != bus_prev_q};
  assign pend_d = (rd_int ? 3'b000 : pend_q) | events;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q      <= 3'b000;
      bus_prev_q  <= 1'b0;
      dead_prev_q <= 1'b0;
      tmo_prev_q  <= 1'b0;
    end else begin
      pend_q      <= pend_d;
      bus_prev_q  <= bus_valid;
      dead_prev_q <= dead_battery_charge_flag;
      tmo_prev_q  <= contact_detect_timeout_flag;
    end
  end

  wire int_active = global_int_en && (|pend_q);

  // ==========================================================================
  // Register read data
  wire [7:0] int_view = {type_q, bus_valid, 1'b0, contact_detect_timeout_flag,
                         state_q == DET_RUN, 1'b0};
  wire [7:0] rd_mux = (reg_addr == `OFS_CONTROL_FIRST)  ? ctrl1_q :
                      (reg_addr == `OFS_INTERRUPT)      ? int_view :
                      (reg_addr == `OFS_ENABLE_CONTROL) ? ctrl2_q :
                      (reg_addr == `OFS_OUTPUT_CONFIG)  ? ctrl3_q : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)      rdata_q <= 8'h00;
    else if (reg_rd) rdata_q <= rd_mux;
  end

  // ==========================================================================
  // Power gating and switch control
  wire osc_off = low_power_select && !bus_valid && !usb_switch_control
                 && !ctrl1_q[`BIT_CHARGE_PUMP];
  wire reg_on  = regulated_output_enable &&
                 (regulated_output_assert_timing ? bus_valid : complete_q);

  // ==========================================================================
  // Outputs
  assign reg_rdata          = rdata_q;
  assign det_start          = start_now;
  assign det_abort          = exit_now;
  assign det_running        = state_q == DET_RUN;
  assign downstream_port_detect_method = ctrl3_q[`BIT_PORT_METHOD];
  assign source_time_long   = ctrl1_q[`BIT_SOURCE_TIME];
  assign contact_detect_enable = ctrl2_q[`BIT_CONTACT_DET_EN];
  assign enable_out_third   = ctrl2_q[2];
  assign enable_out_second  = ctrl2_q[1];
  assign enable_out_first   = ctrl2_q[0];
  assign regulated_output   = reg_on;
  assign usb_switch_closed  = usb_switch_control && (state_q == DET_IDLE)
                              && !osc_off;
  assign analog_switch_hiz  = osc_off;
  assign charge_pump_enable = ctrl1_q[`BIT_CHARGE_PUMP];
  assign oscillator_stop    = osc_off;
  assign interrupt_out      = int_polarity ? int_active : !int_active;

endmodule : charger_detect_enable_control

//--- charger_detect_enable_control_properties.sv
// Port-level checker of the charger control block
`timescale 1ns/10ps
module charger_detect_enable_control_checker #(
  parameter int DEBOUNCE_CYCLES = 600000
) (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  // Detection link
  input wire logic       dead_battery_charge_flag,
  input wire logic       contact_detect_timeout_flag,
  input wire logic       det_start,
  input wire logic       det_abort,
  input wire logic       det_running,
  // Outputs
  input wire logic       enable_out_third,
  input wire logic       enable_out_second,
  input wire logic       enable_out_first,
  input wire logic       regulated_output,
  input wire logic       usb_switch_closed,
  input wire logic       analog_switch_hiz,
  input wire logic       charge_pump_enable,
  input wire logic       oscillator_stop,
  input wire logic       interrupt_out
);
  logic ien_q;
  logic pol_q;
  logic loe_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // ======
  // Shadow of host-written interrupt enable, polarity and regulator enable
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ien_q <= 1'h0;
      pol_q <= 1'h0;
      loe_q <= 1'h0;
    end else if (reg_wr && reg_addr == 8'h01) begin
      ien_q <= reg_wdata[6];
      pol_q <= reg_wdata[7];
    end else if (reg_wr && reg_addr == 8'h04) begin
      loe_q <= reg_wdata[2];
    end
  end

  // ======
  // Properties
  start_from_idle_a: assert property (det_start |-> !det_running ##1 det_running)
    else $error("start not followed by running");
  switch_open_run_a: assert property (det_running |-> !usb_switch_closed)
    else $error("data switch closed during detection");
  timeout_exit_a: assert property (det_abort |->
    $rose(contact_detect_timeout_flag) ##1 !det_running)
    else $error("abort without timeout rise or run kept");
  osc_stop_gate_a: assert property (oscillator_stop |->
    !usb_switch_closed && !charge_pump_enable)
    else $error("oscillator stopped while switch or pump on");
  hiz_switch_open_a: assert property (analog_switch_hiz |-> !usb_switch_closed)
    else $error("switch closed in high impedance state");
  masked_pin_idle_a: assert property (!ien_q |-> interrupt_out == !pol_q)
    else $error("interrupt pin active while masked");
  event_raises_pin_a: assert property ($rose(dead_battery_charge_flag) && ien_q && !reg_wr
    |=> interrupt_out == pol_q) else $error("event did not raise pin");
  pending_held_a: assert property (ien_q && interrupt_out == pol_q && !reg_rd && !reg_wr
    |=> interrupt_out == pol_q) else $error("pending dropped without read");
  forced_outputs_a: assert property (reg_wr && reg_addr == 8'h03 && reg_wdata[3] |=>
    {enable_out_third, enable_out_second, enable_out_first} == $past(reg_wdata[2:0]))
    else $error("forced field not on enable outputs");
  reg_out_off_a: assert property (!loe_q |-> !regulated_output)
    else $error("regulated output on while disabled");

  // Main scenarios reached
  abort_seen_c: cover property (det_abort);
  osc_stop_c: cover property (oscillator_stop);
  force_seen_c: cover property (reg_wr && reg_addr == 8'h03 && reg_wdata[3]);
endmodule : charger_detect_enable_control_checker

bind charger_detect_enable_control charger_detect_enable_control_checker #(
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) charger_detect_enable_control_checker_i (
  .sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .dead_battery_charge_flag,
  .contact_detect_timeout_flag, .det_start, .det_abort, .det_running, .enable_out_third,
  .enable_out_second, .enable_out_first, .regulated_output, .usb_switch_closed,
  .analog_switch_hiz, .charge_pump_enable, .oscillator_stop, .interrupt_out
);

//--- det_seq_model.sv
// Behavioural model of the charger-type detection sequencer
`timescale 1ns/10ps
module det_seq_model (
  // Clock
  input  wire logic       sys_clk,
  // Requests from the block
  input  wire logic       det_start,
  input  wire logic       det_abort,
  // Result code and run length set by the bench
  input  wire logic [2:0] type_code,
  input  wire logic [7:0] delay,
  // Answer to the block
  output logic            det_done,
  output logic      [2:0] det_result
);
  logic       busy_q;
  logic [7:0] cnt_q;

  // Idle at power-up
  initial begin
    busy_q = 1'h0;
    cnt_q = 8'h00;
    det_done = 1'h0;
    det_result = 3'h0;
  end

  // Run for delay plus one cycles after a start, then one done pulse carrying the code
  always @(posedge sys_clk) begin
    det_done <= 1'h0;
    det_result <= ~det_result; // Result flips to its complement every clock; it carries the code only with the done pulse
    if (det_start) begin
      busy_q <= 1'h1;
      cnt_q <= delay;
    end else if (det_abort) begin
      busy_q <= 1'h0;
    end else if (busy_q && cnt_q == 8'h00) begin
      busy_q <= 1'h0;
      det_done <= 1'h1;
      det_result <= type_code;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule : det_seq_model

//--- test_charger_detect_enable_control.sv
// Self-checking bench of the charger control block
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
  $display("BAD %0t got %0h expected %0h", $time, (a), (e)); end end
module test_charger_detect_enable_control;
  logic       sys_clk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, ext_enable = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, delay = 8'h0A, reg_rdata;
  logic       bus_voltage_comparator = 1'h0, dead_battery_charge_flag = 1'h0, seen;
  logic       contact_detect_timeout_flag = 1'h0, det_done, det_start, det_abort, det_running;
  logic       downstream_port_detect_method, source_time_long, contact_detect_enable;
  logic       enable_out_third, enable_out_second, enable_out_first, regulated_output;
  logic       usb_switch_closed, analog_switch_hiz, charge_pump_enable, oscillator_stop;
  logic       interrupt_out;
  logic [2:0] det_result, type_code = 3'h0;
  int         err_total = 0, total_checks = 0;
  wire  [2:0] enables = {enable_out_third, enable_out_second, enable_out_first};

  charger_detect_enable_control #(.DEBOUNCE_CYCLES(8)) charger_detect_enable_control_i (
    .sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .bus_voltage_comparator, .ext_enable, .det_done, .det_result, .dead_battery_charge_flag,
    .contact_detect_timeout_flag, .det_start, .det_abort, .det_running,
    .downstream_port_detect_method, .source_time_long, .contact_detect_enable,
    .enable_out_third, .enable_out_second, .enable_out_first, .regulated_output,
    .usb_switch_closed, .analog_switch_hiz, .charge_pump_enable, .oscillator_stop,
    .interrupt_out);
  det_seq_model det_seq_model_i (.sys_clk, .det_start, .det_abort, .type_code, .delay,
    .det_done, .det_result);

  // Clock and bus-cycle tasks, inputs change 2 ns after the rising edge
  always #25 sys_clk = ~sys_clk;
  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    tick();
    reg_wr = 1'h0;
    tick();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'h1;
    tick();
    reg_rd = 1'h0;
    tick();
    `CHK(reg_rdata, e)
  endtask : rd
  task automatic wait_idle();
    for (int i = 0; i < 80 && det_running; i++) tick();
    tick(2);
  endtask : wait_idle
  task automatic detect(input logic [2:0] t, input logic [7:0] ctl);
    type_code = t;
    wr(8'h01, ctl);
    `CHK(det_running, 1'h1)
    `CHK(usb_switch_closed, 1'h0)
    wait_idle();
  endtask : detect
  // Expected enable pattern from suspend, compliance, external enable and type
  function automatic logic [2:0] pat(input logic s, input logic c, input logic e,
                                     input logic [2:0] t);
    if (e || t == 3'h0 || t == 3'h6 || (t == 3'h1 && c)) return s ? 3'h1 : 3'h7;
    if (t == 3'h1 || t == 3'h4) return 3'h4;
    return (t == 3'h7) ? 3'h0 : 3'h2;
  endfunction : pat
  task automatic print_verdict();
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  // Cut a hung run short
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    print_verdict();
  end

  // Test sequence
  initial begin
    tick(20);
    nrst = 1'h1;
    tick(3);
    rd(8'h01, 8'h09);
    rd(8'h03, 8'h87);
    rd(8'h04, 8'h0B);
    rd(8'h05, 8'h00);
    `CHK({oscillator_stop, analog_switch_hiz, interrupt_out}, 3'h7)
    wr(8'h01, 8'h19);
    `CHK({oscillator_stop, analog_switch_hiz, charge_pump_enable}, 3'h1)
    wr(8'h01, 8'h49);
    bus_voltage_comparator = 1'h1;
    tick(4);
    bus_voltage_comparator = 1'h0;
    tick(20);
    `CHK({det_running, interrupt_out}, 2'h1)
    type_code = 3'h3;
    bus_voltage_comparator = 1'h1;
    for (int i = 0; i < 40 && !det_running; i++) tick();
    `CHK({det_running, interrupt_out}, 2'h2)
    wait_idle();
    `CHK(enables, 3'h2)
    rd(8'h02, 8'h70);
    `CHK(interrupt_out, 1'h1)
    for (int k = 0; k < 32; k++) begin
      wr(8'h03, {3'h4, k[3], 4'h5});
      wr(8'h04, {4'h0, k[4], 3'h3});
      detect(k[2:0], {2'h1, k[3], 2'h1, k[4], 2'h3});
      `CHK(enables, pat(k[3], k[4], 1'h0, k[2:0]))
      `CHK({usb_switch_closed, source_time_long}, {k[3], k[4]})
      rd(8'h01, {2'h1, k[3], 2'h1, k[4], 2'h1});
      rd(8'h02, {k[2:0], 5'h10});
    end
    ext_enable = 1'h1;
    tick(6);
    `CHK(enables, pat(1'h1, 1'h1, 1'h1, 3'h7))
    ext_enable = 1'h0;
    tick(6);
    for (int k = 0; k < 8; k++) begin
      wr(8'h03, {k[0], 4'h1, k[2:0]});
      `CHK({contact_detect_enable, enables}, {k[0], k[2:0]})
    end
    detect(3'h3, 8'h4B);
    `CHK(enables, 3'h7)
    rd(8'h03, 8'h8F);
    wr(8'h03, 8'h80);
    `CHK(enables, 3'h2)
    dead_battery_charge_flag = 1'h1;
    tick(2);
    `CHK(interrupt_out, 1'h0)
    dead_battery_charge_flag = 1'h0;
    wr(8'h01, 8'h09);
    `CHK(interrupt_out, 1'h1)
    wr(8'h01, 8'h49);
    `CHK(interrupt_out, 1'h0)
    rd(8'h02, 8'h70);
    `CHK(interrupt_out, 1'h1)
    wr(8'h01, 8'hC9);
    contact_detect_timeout_flag = 1'h1;
    tick(2);
    `CHK(interrupt_out, 1'h1)
    rd(8'h02, 8'h74);
    contact_detect_timeout_flag = 1'h0;
    `CHK(interrupt_out, 1'h0)
    delay = 8'h28;
    for (int k = 0; k < 2; k++) begin
      wr(8'h04, {7'h05, ~k[0]});
      wr(8'h01, 8'h4B);
      contact_detect_timeout_flag = 1'h1;
      seen = 1'h0;
      for (int i = 0; i < 4; i++) begin
        #1 seen = seen | det_abort;
        tick();
      end
      `CHK({seen, det_running}, {~k[0], k[0]})
      contact_detect_timeout_flag = 1'h0;
      wait_idle();
    end
    wr(8'h04, 8'h16);
    `CHK({downstream_port_detect_method, regulated_output}, 2'h3)
    wr(8'h04, 8'h04);
    bus_voltage_comparator = 1'h0;
    tick(20);
    `CHK(regulated_output, 1'h0)
    bus_voltage_comparator = 1'h1;
    for (int i = 0; i < 40 && !det_running; i++) tick();
    `CHK({det_running, regulated_output}, 2'h2)
    wait_idle();
    `CHK(regulated_output, 1'h1)
    wr(8'h04, 8'h00);
    `CHK(regulated_output, 1'h0)
    print_verdict();
  end
endmodule : test_charger_detect_enable_control
